// [aeiu_unit.sv]
`timescale 1ns/1ps
module aeiu_unit
	import aeiu_pkg::*;
(
	input logic sys_clk, // core clock, 10 MHz
	input logic reset, // synchronous, active high
	input logic hsel, // ahb slave select
	input logic [31:0] haddr, // ahb address
	input logic [1:0] htrans, // ahb transfer type
	input logic hwrite, // ahb write
	input logic [2:0] hsize, // ahb size, word only
	input logic [31:0] hwdata, // ahb write data
	input logic hready, // ahb bus ready
	output logic hreadyout, // ahb slave ready
	output logic [31:0] hrdata, // ahb read data
	output logic hresp, // ahb response, always okay
	output logic irq, // level interrupt
	input logic op_valid, // pipeline issues an operation
	output logic op_ready, // unit can take an operation
	input aeiu_op_s op_in, // decoded operation and operands
	output logic res_valid, // one-cycle result strobe
	output aeiu_res_s res_out, // result word and exception
	input logic acc_wr_en, // pipeline writes an accumulator
	input logic [1:0] acc_wr_sel, // accumulator written
	input aeiu_acc_s acc_wr_data, // value written
	output logic mem_req, // byte fetch request
	output logic [31:0] mem_addr, // byte fetch address
	input logic mem_ack, // fetch finished
	input logic [7:0] mem_rdata, // fetched byte
	input aeiu_exc_e mem_fault // fault from translation or watch
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	wire aeiu_acc_s [ACC_N-1:0] acc_file;
	logic [31:0] ctrl_q, ctrl_d;
	logic [31:0] cfg_q;
	logic [STS_W-1:0] sts_q, sts_d, mask_q;
	logic wr_pend_q;
	logic [DEC_W-1:0] wr_addr_q;
	logic [31:0] hrdata_q;
	logic res_valid_q;
	aeiu_res_s res_q, res_d;
	logic ld_busy_q;
	logic [31:0] ld_addr_q;

	// ----------------------------------------------------------------
	// accumulator file
	// ----------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < ACC_N; gi++)
		begin : g_acc
			aeiu_acc_s ent_q;
			// only the pipeline write port changes an entry
			always_ff @(posedge sys_clk)
			begin
				if (reset)
					ent_q <= '0;
				else if (acc_wr_en && acc_wr_sel == gi[1:0])
					ent_q <= acc_wr_data;
			end
			assign acc_file[gi] = ent_q;
		end
	endgenerate

	// ----------------------------------------------------------------
	// operation decode
	// ----------------------------------------------------------------
	wire op_take = op_valid & op_ready;
	wire ext_en = cfg_q[CFG_EN_BIT];
	wire opc_legal = (op_in.opc inside {opc_word_extract_var_shift,
		opc_word_extract_var_round, opc_word_extract_var_round_sat,
		opc_half_extract_var_sat, opc_half_extract_imm_sat,
		opc_insert_field_var, opc_load_byte_indexed});
	wire is_word = op_in.opc inside {opc_word_extract_var_shift,
		opc_word_extract_var_round, opc_word_extract_var_round_sat};
	wire is_half = op_in.opc inside {opc_half_extract_var_sat,
		opc_half_extract_imm_sat};
	wire is_load = op_in.opc == opc_load_byte_indexed;
	wire do_ok = op_take & opc_legal & ext_en;
	wire ld_start = do_ok & is_load;

	// ----------------------------------------------------------------
	// extract datapath
	// ----------------------------------------------------------------
	wire aeiu_acc_s acc_rd = acc_file[op_in.sum_register_select];
	wire [63:0] acc_v = {acc_rd.hi, acc_rd.lo};
	wire [SHAMT_W-1:0] sa = op_in.field_source_reg[SHAMT_W-1:0];
	wire [SHAMT_W-1:0] sa_m1 = sa - 5'h01;
	wire [63:0] shifted = $signed(acc_v) >>> sa;
	// keep one extra bit so that the rounding carry cannot be lost
	wire [64:0] pre_rnd = $signed({acc_v[63], acc_v}) >>> sa_m1;
	wire [64:0] rnd_sum = pre_rnd + 65'h1;
	wire [63:0] te = (sa == '0) ? acc_v : rnd_sum[64:1];
	wire word_pos = ~acc_v[63] & ((shifted[63:WORD_SIGN] != '0) |
		(te[63:WORD_SIGN] != '0));
	wire word_neg = acc_v[63] & (shifted[63:WORD_SIGN] != '1);
	wire word_ovf = word_pos | word_neg;
	wire half_pos = ~shifted[63] & (shifted[62:HALF_SIGN] != '0);
	wire half_neg = shifted[63] & (shifted[62:HALF_SIGN] != '1);
	wire half_ovf = half_pos | half_neg;
	wire [31:0] half_val = half_pos ? HALF_MAX :
		half_neg ? HALF_MIN : shifted[31:0];
	wire [31:0] rsat_val = word_pos ? WORD_MAX :
		word_neg ? WORD_MIN : te[31:0];

	// ----------------------------------------------------------------
	// insert datapath
	// ----------------------------------------------------------------
	wire [5:0] ins_pos = ctrl_q[POS_MSB:POS_LSB];
	wire [5:0] ins_size = ctrl_q[SIZE_MSB:SIZE_LSB];
	wire [6:0] ins_lsb = {1'b0, ins_pos};
	wire [6:0] ins_msb = ins_lsb + {1'b0, ins_size} - 7'h01;
	// size zero wraps msb below lsb; target is then returned unchanged
	wire ins_bad = $signed(ins_msb) < $signed(ins_lsb);
	wire [63:0] ins_ones = (64'h1 << ins_size) - 64'h1;
	wire [63:0] ins_mask64 = ins_ones << ins_pos;
	wire [31:0] ins_mask = ins_mask64[31:0];
	wire [31:0] ins_src = op_in.field_source_reg << ins_pos;
	// pos/size outside the legal range leave the result meaningless
	wire [31:0] ins_val = ins_bad ? op_in.dest_reg :
		(op_in.dest_reg & ~ins_mask) | (ins_src & ins_mask);

	// ----------------------------------------------------------------
	// result select
	// ----------------------------------------------------------------
	always_comb
	begin
		res_d.data = '0;
		res_d.exc = exc_none;
		if (!opc_legal)
			res_d.exc = exc_reserved;
		else if (!ext_en)
			res_d.exc = exc_disabled;
		else
		begin
			unique case (op_in.opc)
				opc_word_extract_var_shift:
					res_d.data = shifted[31:0];
				opc_word_extract_var_round:
					res_d.data = te[31:0];
				opc_word_extract_var_round_sat:
					res_d.data = rsat_val;
				opc_half_extract_var_sat,
				opc_half_extract_imm_sat:
					res_d.data = half_val;
				opc_insert_field_var:
					res_d.data = ins_val;
				default:
					res_d.data = '0;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// operation sequencing and byte load
	// ----------------------------------------------------------------
	// a load stalls issue until memory answers; extracts take one cycle
	wire ld_done = ld_busy_q & mem_ack;
	assign op_ready = ~ld_busy_q;
	assign mem_req = ld_busy_q;
	assign mem_addr = ld_addr_q;
	assign res_valid = res_valid_q;
	assign res_out = res_q;

	always_ff @(posedge sys_clk)
	begin
		if (reset)
			ld_busy_q <= 1'b0;
		else if (ld_start)
			ld_busy_q <= 1'b1;
		else if (ld_done)
			ld_busy_q <= 1'b0;
	end

	always_ff @(posedge sys_clk)
	begin
		if (reset)
			ld_addr_q <= '0;
		else if (ld_start)
			ld_addr_q <= op_in.dest_reg + op_in.base_reg;
	end

	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			res_valid_q <= 1'b0;
			res_q <= '0;
		end
		else if (ld_done)
		begin
			res_valid_q <= 1'b1;
			res_q.exc <= mem_fault;
			res_q.data <= (mem_fault == exc_none) ?
				{24'h000000, mem_rdata} : '0;
		end
		else
		begin
			res_valid_q <= op_take & ~(do_ok & is_load);
			res_q <= res_d;
		end
	end

	// ----------------------------------------------------------------
	// bus slave
	// ----------------------------------------------------------------
	wire ahb_take = hsel & hready & htrans[HTRANS_ACT_BIT];
	wire [DEC_W-1:0] a_ofs = haddr[DEC_W-1:0];
	wire sw_ctrl = wr_pend_q & (wr_addr_q == OFS_CTRL);
	wire sw_cfg = wr_pend_q & (wr_addr_q == OFS_CFG);
	wire sw_sts = wr_pend_q & (wr_addr_q == OFS_STS);
	wire sw_mask = wr_pend_q & (wr_addr_q == OFS_MASK);
	wire [31:0] rd_mux = (a_ofs == OFS_CTRL) ? ctrl_q :
		(a_ofs == OFS_CFG) ? cfg_q :
		(a_ofs == OFS_STS) ? {30'h0, sts_q} :
		(a_ofs == OFS_MASK) ? {30'h0, mask_q} : '0;

	// zero wait states: every transfer completes in its data phase
	assign hreadyout = 1'b1;
	assign hresp = HRESP_OKAY;
	assign hrdata = hrdata_q;

	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= '0;
			hrdata_q <= '0;
		end
		else
		begin
			wr_pend_q <= ahb_take & hwrite;
			wr_addr_q <= a_ofs;
			if (ahb_take & ~hwrite)
				hrdata_q <= rd_mux;
		end
	end

	// ----------------------------------------------------------------
	// control, status and interrupt
	// ----------------------------------------------------------------
	wire ovf_set = op_take & opc_legal & ext_en &
		((is_word & word_ovf) | (is_half & half_ovf));
	wire ldexc_set = ld_done & (mem_fault != exc_none);
	wire [STS_W-1:0] sts_evt = {ldexc_set, ovf_set};
	wire [STS_W-1:0] sts_w1c = sw_sts ? hwdata[STS_W-1:0] : '0;

	always_comb
	begin
		ctrl_d = ctrl_q;
		if (sw_ctrl)
			ctrl_d = (ctrl_q & ~CTRL_WMASK) | (hwdata & CTRL_WMASK);
		// a hardware overflow beats a software clear in the same cycle
		if (ovf_set)
			ctrl_d[OVF_FLAG_BIT] = 1'b1;
		sts_d = (sts_q & ~sts_w1c) | sts_evt;
	end

	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			ctrl_q <= CTRL_RST;
			cfg_q <= CFG_RST;
			sts_q <= STS_RST;
			mask_q <= STS_RST;
		end
		else
		begin
			ctrl_q <= ctrl_d;
			sts_q <= sts_d;
			if (sw_cfg)
				cfg_q <= hwdata & (32'h1 << CFG_EN_BIT);
			if (sw_mask)
				mask_q <= hwdata[STS_W-1:0];
		end
	end

	assign irq = |(sts_q & mask_q);

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	wire ext_take = do_ok & (is_word | is_half);

	a_zero_shift: assert property (
		@(posedge sys_clk) disable iff (reset)
		ext_take && op_in.opc == opc_word_extract_var_shift &&
		op_in.field_source_reg[SHAMT_W-1:0] == '0
		|=> res_valid && res_out.data == $past(acc_v[31:0]))
		else $error("zero shift does not pass accumulator low word");

	a_plain_word: assert property (
		@(posedge sys_clk) disable iff (reset)
		ext_take && op_in.opc == opc_word_extract_var_shift
		|=> res_out.data == $past(shifted[31:0]))
		else $error("plain word extract result wrong");

	a_acc_kept: assert property (
		@(posedge sys_clk) disable iff (reset)
		ext_take && !acc_wr_en |=> acc_file == $past(acc_file))
		else $error("extract changed an accumulator");

	a_round_clamp: assert property (
		@(posedge sys_clk) disable iff (reset)
		ext_take && op_in.opc == opc_word_extract_var_round_sat &&
		word_pos |=> res_out.data == WORD_MAX)
		else $error("positive word clamp missing");

	a_neg_clamp: assert property (
		@(posedge sys_clk) disable iff (reset)
		ext_take && op_in.opc == opc_word_extract_var_round_sat &&
		word_neg |=> res_out.data == WORD_MIN)
		else $error("negative word clamp missing");

	a_word_ovf: assert property (
		@(posedge sys_clk) disable iff (reset)
		ext_take && is_word && word_ovf |=> ctrl_q[OVF_FLAG_BIT] &&
		sts_q[STS_OVF_BIT])
		else $error("word overflow flag not set");

	a_half_sat: assert property (
		@(posedge sys_clk) disable iff (reset)
		ext_take && is_half && half_neg |=> res_out.data == HALF_MIN)
		else $error("negative halfword clamp missing");

	a_half_flag: assert property (
		@(posedge sys_clk) disable iff (reset)
		ext_take && is_half && half_ovf |=> ctrl_q[OVF_FLAG_BIT] &&
		sts_q[STS_OVF_BIT])
		else $error("halfword saturation flag not set");

	a_half_noflag: assert property (
		@(posedge sys_clk) disable iff (reset)
		ext_take && is_half && !half_ovf && !ctrl_q[OVF_FLAG_BIT] &&
		!sw_ctrl |=> !ctrl_q[OVF_FLAG_BIT])
		else $error("halfword flag set without saturation");

	a_no_ext_exc: assert property (
		@(posedge sys_clk) disable iff (reset)
		ext_take |=> res_valid && res_out.exc == exc_none)
		else $error("extract raised an exception");

	a_full_insert: assert property (
		@(posedge sys_clk) disable iff (reset)
		do_ok && op_in.opc == opc_insert_field_var && ins_pos == '0 &&
		ins_size == 6'h20 |=> res_out.data == $past(op_in.field_source_reg))
		else $error("full-width insert does not copy source");

	a_byte_zext: assert property (
		@(posedge sys_clk) disable iff (reset)
		ld_done && mem_fault == exc_none |=> res_valid &&
		res_out.data[31:BYTE_W] == '0 && op_ready)
		else $error("byte load not zero extended");

	a_load_addr: assert property (
		@(posedge sys_clk) disable iff (reset)
		ld_start |=> mem_req &&
		mem_addr == $past(op_in.dest_reg + op_in.base_reg))
		else $error("byte load address is not index plus base");

endmodule : aeiu_unit

// [aeiu_pkg.sv]
package aeiu_pkg;

	// ----------------------------------------------------------------
	// register map (byte offsets on the bus)
	// ----------------------------------------------------------------
	localparam int unsigned DEC_W = 8;
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_CFG = 8'h04;
	localparam logic [7:0] OFS_STS = 8'h08;
	localparam logic [7:0] OFS_MASK = 8'h0C;

	// ----------------------------------------------------------------
	// field layouts and reset values
	// ----------------------------------------------------------------
	localparam int unsigned POS_LSB = 0;
	localparam int unsigned POS_MSB = 5;
	localparam int unsigned SIZE_LSB = 7;
	localparam int unsigned SIZE_MSB = 12;
	localparam int unsigned OVF_FLAG_BIT = 23;
	localparam logic [31:0] CTRL_WMASK = 32'h00801FBF;
	localparam logic [31:0] CTRL_RST = 32'h00000000;
	localparam int unsigned CFG_EN_BIT = 0;
	localparam logic [31:0] CFG_RST = 32'h00000001;
	localparam int unsigned STS_W = 2;
	localparam int unsigned STS_OVF_BIT = 0;
	localparam int unsigned STS_LDEXC_BIT = 1;
	localparam logic [1:0] STS_RST = 2'h0;
	localparam int unsigned HTRANS_ACT_BIT = 1;
	localparam logic HRESP_OKAY = 1'b0;

	// ----------------------------------------------------------------
	// datapath constants
	// ----------------------------------------------------------------
	localparam int unsigned ACC_N = 4;
	localparam int unsigned SHAMT_W = 5;
	localparam int unsigned WORD_SIGN = 31;
	localparam int unsigned HALF_SIGN = 15;
	localparam int unsigned BYTE_W = 8;
	localparam logic [31:0] WORD_MAX = 32'h7FFFFFFF;
	localparam logic [31:0] WORD_MIN = 32'h80000000;
	localparam logic [31:0] HALF_MAX = 32'h00007FFF;
	localparam logic [31:0] HALF_MIN = 32'hFFFF8000;

	typedef enum logic [2:0] {
		opc_word_extract_var_shift,
		opc_word_extract_var_round,
		opc_word_extract_var_round_sat,
		opc_half_extract_var_sat,
		opc_half_extract_imm_sat,
		opc_insert_field_var,
		opc_load_byte_indexed
	} aeiu_opc_e;

	typedef enum logic [2:0] {
		exc_none,
		exc_reserved,
		exc_disabled,
		exc_tlb_refill,
		exc_tlb_invalid,
		exc_addr_error,
		exc_watch
	} aeiu_exc_e;

	typedef struct packed {
		aeiu_opc_e opc;
		logic [1:0] sum_register_select;
		logic [31:0] field_source_reg;
		logic [31:0] dest_reg;
		logic [31:0] base_reg;
	} aeiu_op_s;

	typedef struct packed {
		logic [31:0] data;
		aeiu_exc_e exc;
	} aeiu_res_s;

	typedef struct packed {
		logic [31:0] hi;
		logic [31:0] lo;
	} aeiu_acc_s;

endpackage : aeiu_pkg

// [aeiu_mem_model.sv]
`timescale 1ns/1ps
module aeiu_mem_model
	import aeiu_pkg::*;
(
	input logic sys_clk, // core clock
	input logic reset, // sync reset
	input logic mem_req, // fetch request
	input logic [31:0] mem_addr, // fetch address
	input int dly, // wait cycles before answering
	input aeiu_exc_e flt, // fault to report
	output logic mem_ack, // one-cycle answer
	output logic [7:0] mem_rdata, // fetched byte
	output aeiu_exc_e mem_fault, // fault code
	output logic [31:0] last_addr // address of last fetch
);
	// ----
	// byte memory: contents derive from the address
	// ----
	int cnt;
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			mem_ack <= 1'b0;
			cnt <= 0;
			mem_rdata <= 8'h00;
			mem_fault <= exc_reserved;
			last_addr <= 32'h0;
		end
		else if (mem_req && !mem_ack && cnt >= dly)
		begin
			mem_ack <= 1'b1;
			mem_rdata <= mem_addr[7:0] ^ 8'hC3;
			mem_fault <= flt;
			last_addr <= mem_addr;
			cnt <= 0;
		end
		else
		begin
			// idle lines carry junk so stale data is never mistaken
			mem_ack <= 1'b0;
			mem_rdata <= ~mem_rdata;
			mem_fault <= exc_reserved;
			cnt <= (mem_req && !mem_ack) ? cnt + 1 : 0;
		end
	end
endmodule : aeiu_mem_model

// [tb.sv]
`timescale 1ns/1ps
module tb;
	import aeiu_pkg::*;
	logic sys_clk = 1'b0;
	logic reset = 1'b1;
	logic hsel = 1'b0, hwrite = 1'b0, op_valid = 1'b0, acc_wr_en = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, mem_addr, la, rd;
	logic [1:0] htrans = 2'h0, acc_wr_sel = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic hready, hreadyout, hresp, irq, op_ready, res_valid, mem_req;
	logic mem_ack;
	logic [7:0] mem_rdata;
	aeiu_exc_e mem_fault;
	aeiu_exc_e flt = exc_none;
	aeiu_op_s op_in = '0;
	aeiu_res_s res_out, rr;
	aeiu_acc_s acc_wr_data = '0;
	logic [63:0] accm [4];
	int fails = 0, compares = 0, dly = 0;
	logic [63:0] va [8] = '{64'h000000007FFFFFFF, 64'hFFFFFFFF80000000,
		64'h0000000100000000, 64'h8000000000000000, 64'h0000000000000003,
		64'h00000000FFFFFFFF, 64'hFFFFFFFFFFFFFFFD, 64'h0000000000012340};
	int vs [8] = '{0, 0, 1, 31, 1, 1, 1, 4};
	int ip [5] = '{0, 31, 4, 24, 3};
	int iz [5] = '{32, 1, 8, 8, 5};
	int lf [5] = '{0, 3, 4, 5, 6};
	assign hready = hreadyout;
	always #50 sys_clk = ~sys_clk;
	aeiu_unit DUT (.sys_clk(sys_clk), .reset(reset), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
		.hrdata(hrdata), .hresp(hresp), .irq(irq), .op_valid(op_valid),
		.op_ready(op_ready), .op_in(op_in), .res_valid(res_valid),
		.res_out(res_out), .acc_wr_en(acc_wr_en), .acc_wr_sel(acc_wr_sel),
		.acc_wr_data(acc_wr_data), .mem_req(mem_req), .mem_addr(mem_addr),
		.mem_ack(mem_ack), .mem_rdata(mem_rdata), .mem_fault(mem_fault));
	aeiu_mem_model mem (.sys_clk(sys_clk), .reset(reset), .mem_req(mem_req),
		.mem_addr(mem_addr), .dly(dly), .flt(flt), .mem_ack(mem_ack),
		.mem_rdata(mem_rdata), .mem_fault(mem_fault), .last_addr(la));
	// ----
	// reporting
	// ----
	task end_of_test;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : end_of_test
	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e)
		begin
			fails++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	// ----
	// access tasks; w selects hready, op_ready or res_valid
	// ----
	task wt(input int w);
		int i;
		logic s;
		for (i = 0; i < 50; i++)
		begin
			@(posedge sys_clk);
			s = (w == 0) ? hready : (w == 1) ? op_ready : res_valid;
			if (s === 1'b1)
				return;
		end
		fails++;
		$display("mismatch wait %0d expected done seen timeout", w);
		end_of_test();
	endtask : wt
	task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		wt(0);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wt(0);
		rd = hrdata;
	endtask : ahb
	task aw(input logic [1:0] s, input logic [63:0] v);
		acc_wr_en <= 1'b1;
		acc_wr_sel <= s;
		acc_wr_data <= v;
		accm[s] = v;
		@(posedge sys_clk);
		acc_wr_en <= 1'b0;
	endtask : aw
	task op(input aeiu_opc_e c, input logic [1:0] s, input logic [31:0] a,
		input logic [31:0] b, input logic [31:0] e);
		op_valid <= 1'b1;
		op_in <= '{c, s, a, b, e};
		wt(1);
		op_valid <= 1'b0;
		wt(2);
		rr = res_out;
	endtask : op
	// ----
	// reference arithmetic
	// ----
	function automatic logic [63:0] sh(logic [63:0] a, int s);
		return $signed(a) >>> s;
	endfunction : sh
	function automatic logic [63:0] rn(logic [63:0] a, int s);
		logic [64:0] t;
		if (s == 0)
			return a;
		t = $signed({a[63], a}) >>> (s - 1);
		t = t + 65'h1;
		return t[64:1];
	endfunction : rn
	function automatic logic [32:0] ex(aeiu_opc_e c, logic [63:0] a, int s);
		logic [63:0] p, q;
		logic op_, on_;
		p = sh(a, s);
		q = rn(a, s);
		op_ = $signed(p) > 64'sh7FFFFFFF || $signed(q) > 64'sh7FFFFFFF;
		on_ = $signed(p) < $signed(64'hFFFFFFFF80000000);
		case (c)
			opc_word_extract_var_shift: return {op_ | on_, p[31:0]};
			opc_word_extract_var_round: return {op_ | on_, q[31:0]};
			opc_word_extract_var_round_sat:
				return {op_ | on_, op_ ? WORD_MAX : on_ ? WORD_MIN : q[31:0]};
			default:
			begin
				if ($signed(p) > 64'sh7FFF)
					return {1'b1, HALF_MAX};
				if ($signed(p) < $signed(64'hFFFFFFFFFFFF8000))
					return {1'b1, HALF_MIN};
				return {1'b0, p[31:0]};
			end
		endcase
	endfunction : ex
	// ----
	// main sequence
	// ----
	initial
	begin
		int i, k;
		logic [32:0] e;
		logic [63:0] m;
		logic [31:0] ea;
		repeat (8) @(posedge sys_clk);
		reset <= 1'b0;
		@(posedge sys_clk);
		ahb(0, 32'(OFS_CTRL), 32'h0);
		chk("ctrl rst", rd, CTRL_RST);
		ahb(0, 32'(OFS_CFG), 32'h0);
		chk("cfg rst", rd, CFG_RST);
		ahb(0, 32'h10, 32'h0);
		chk("unmapped", rd, 32'h0);
		ahb(1, 32'(OFS_CTRL), 32'hFFFFFFFF);
		ahb(0, 32'(OFS_CTRL), 32'h0);
		chk("ctrl mask", rd, CTRL_WMASK);
		for (i = 0; i < 8; i++)
		begin
			aw(i[1:0], va[i]);
			for (k = 0; k < 5; k++)
			begin
				e = ex(aeiu_opc_e'(k), va[i], vs[i]);
				ahb(1, 32'(OFS_CTRL), 32'h0);
				op(aeiu_opc_e'(k), i[1:0], 32'hFFFFFFE0 | vs[i], 32'h0, 32'h0);
				chk("xdata", rr.data, e[31:0]);
				chk("xexc", 32'(rr.exc), 32'(exc_none));
				ahb(0, 32'(OFS_CTRL), 32'h0);
				chk("ovf flag", 32'(rd[OVF_FLAG_BIT]), 32'(e[32]));
			end
		end
		for (i = 0; i < 4; i++)
		begin
			op(opc_word_extract_var_shift, i[1:0], 32'd31, 32'h0, 32'h0);
			ea = 32'(sh(accm[i], 31));
			chk("acc hold", rr.data, ea);
		end
		ahb(0, 32'(OFS_STS), 32'h0);
		chk("sts ovf", 32'(rd[STS_OVF_BIT]), 32'h1);
		chk("irq masked", 32'(irq), 32'h0);
		ahb(1, 32'(OFS_MASK), 32'h1);
		ahb(0, 32'(OFS_STS), 32'h0);
		chk("irq on", 32'(irq), 32'h1);
		ahb(1, 32'(OFS_STS), 32'h1);
		ahb(0, 32'(OFS_STS), 32'h0);
		chk("sts w1c", rd, 32'h0);
		chk("irq off", 32'(irq), 32'h0);
		// legal pos and size only
		for (k = 0; k < 5; k++)
		begin
			ahb(1, 32'(OFS_CTRL), (iz[k] << SIZE_LSB) | ip[k]);
			op(opc_insert_field_var, 2'h0, 32'hA5C396E7, 32'h12345678, 32'h0);
			m = ((64'h1 << iz[k]) - 64'h1) << ip[k];
			ea = (32'h12345678 & ~m[31:0]) | ((32'hA5C396E7 << ip[k]) & m[31:0]);
			chk("insert", rr.data, ea);
		end
		for (k = 0; k < 5; k++)
		begin
			flt <= aeiu_exc_e'(lf[k]);
			dly <= k;
			op(opc_load_byte_indexed, 2'h0, 32'h0, 32'hF0 + k, 32'h80000F0F);
			ea = 32'h80000FFF + k;
			chk("laddr", la, ea);
			ea = (lf[k] == 0) ? {24'h0, ea[7:0] ^ 8'hC3} : 32'h0;
			chk("ldata", rr.data, ea);
			chk("lexc", 32'(rr.exc), lf[k]);
		end
		ahb(0, 32'(OFS_STS), 32'h0);
		chk("sts ld", 32'(rd[STS_LDEXC_BIT]), 32'h1);
		op(aeiu_opc_e'(3'h7), 2'h0, 32'h0, 32'h0, 32'h0);
		chk("resv", 32'(rr.exc), 32'(exc_reserved));
		ahb(1, 32'(OFS_CFG), 32'h0);
		op(opc_load_byte_indexed, 2'h1, 32'h0, 32'h4, 32'h8);
		chk("dis", 32'(rr.exc), 32'(exc_disabled));
		end_of_test();
	end
endmodule : tb
